/* pkg/scd_params.svh */
// constants for the switch control and fault register bank
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// ==========================================
// instruction field codes
`define SCD_OP_WR_CMD_LOW 5'h14
`define SCD_OP_WR_CMD_MID 5'h15
`define SCD_OP_WR_CMD_HIGH 5'h16
`define SCD_OP_RD_CMD_LOW 5'h04
`define SCD_OP_RD_CMD_MID 5'h05
`define SCD_OP_RD_CMD_HIGH 5'h06
`define SCD_OP_RD_FAULT_ONE 5'h08
`define SCD_OP_RD_FAULT_TWO 5'h09
`define SCD_OP_RD_FAULT_THREE 5'h0a
`define SCD_OP_RD_FAULT_FOUR 5'h0b
`define SCD_OP_RD_FAULT_FIVE 5'h0c
`define SCD_OP_CLEAR_FAULTS 5'h18

// ==========================================
// reset values and fixed fields
`define SCD_CMD_RESET 8'hff
`define SCD_HIGH_UNUSED 6'h3f
`define SCD_FIVE_UNUSED 3'h7
`define SCD_NO_READ 8'hff

// ==========================================
// fault codes
`define SCD_FAULT_NONE 2'h3
`define SCD_FAULT_BATT_OT 2'h2
`define SCD_FAULT_OPEN 2'h1
`define SCD_FAULT_GROUND 2'h0

`endif

/* pkg/scd_pkg.sv */
// types shared by the register bank files
package scd_pkg;
    typedef logic [7:0] scd_byte_t;
    typedef logic [1:0] scd_fault_t;
    typedef logic [4:0] scd_op_t;
endpackage

/* src/scd_fault_latch.sv */
// sticky fault code store for all stages
`include "scd_params.svh"

module scd_fault_latch import scd_pkg::*; #(
    parameter int NSTAGES = 18
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [2*NSTAGES-1:0] faultLive,
    input wire logic clearReq,
    output logic [2*NSTAGES-1:0] faultCode
);
    // ==========================================
    // synchroniser, analog detect is asynchronous
    logic [2*NSTAGES-1:0] meta_q;
    logic [2*NSTAGES-1:0] live_q;
    logic [2*NSTAGES-1:0] code_q;
    logic [2*NSTAGES-1:0] code_d;

    always_ff @(posedge mclk) begin
        meta_q <= faultLive;
        live_q <= meta_q;
    end

    // ==========================================
    // latch
    always_comb begin
        code_d = code_q;
        for (int i = 0; i < NSTAGES; i++) begin
            // (RULE10) live code passes unchanged
            // (RULE13) clear only when gone
            if (live_q[2*i +: 2] != `SCD_FAULT_NONE) begin
                code_d[2*i +: 2] = live_q[2*i +: 2];
            end else if (clearReq) begin
                code_d[2*i +: 2] = `SCD_FAULT_NONE;
            end
        end
    end

    // (RULE9) reset to all ones
    always_ff @(posedge mclk) begin
        if (srst) begin
            code_q <= '1;
        end else begin
            code_q <= code_d;
        end
    end

    assign faultCode = code_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    clear_when_gone_a: assert property (clearReq && live_q[1:0] == `SCD_FAULT_NONE |=> code_q[1:0] == `SCD_FAULT_NONE)
        else $error("stage fault not cleared"); // (RULE13)
    fault_set_wins_a: assert property (live_q[3:2] != `SCD_FAULT_NONE |=> code_q[3:2] == $past(live_q[3:2]))
        else $error("live fault not latched"); // (RULE10)
    fault_sticky_a: assert property (!clearReq && live_q[5:4] == `SCD_FAULT_NONE |=> $stable(code_q[5:4]))
        else $error("latched fault lost"); // (RULE9)
endmodule // scd_fault_latch

/* src/scd_regs.sv */
// serial command and fault code register bank
`include "scd_params.svh"

// Overview of operation
// (RULE1) serial_cmd_low is an 8-bit read/write register, bit i commanding stage i+1, reset 0xff.
// (RULE2) serial_cmd_mid is an 8-bit read/write register, bit i commanding stage i+9, reset 0xff.
// (RULE3) serial_cmd_high holds stage 17 in bit 0 and stage 18 in bit 1, bits 7-2 read as one.
// (RULE4) writes to the upper six bits of serial_cmd_high are dropped and never show on reads.
// (RULE5) fault_codes_one is read-only and packs two-bit codes of stages 1 to 4, lowest pair first.
// (RULE6) fault_codes_two is read-only and packs stages 5 to 8, lowest pair first.
// (RULE7) fault_codes_three is read-only and packs stages 9 to 12, lowest pair first.
// (RULE8) fault_codes_four is read-only and packs stages 13 to 16, lowest pair first.
// (RULE9) fault registers reset to all ones and no controller write changes them.
// (RULE10) a fault code reads 11 ok, 10 battery short or overtemperature, 01 open load, 00 ground short.
// (RULE11) a stage under serial control is on when its command bit is zero and off when it is one.
// (RULE12) fault_codes_five holds stage 17 in bits 1-0, stage 18 in 3-2, live battery status in 4, ones in 7-5.
// (RULE13) the clear instruction, with any data, sets codes back to 11 only where the fault is gone.
// (RULE14) a command write takes effect at the end of the accepted frame and then drives serial stages.
module scd_regs import scd_pkg::*; #(
    parameter int NSTAGES = 18
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cmdValid,
    input wire scd_op_t cmdCode,
    input wire scd_byte_t cmdData,
    output logic rdValid,
    output scd_byte_t rdData,
    input wire logic [2*NSTAGES-1:0] stageFault,
    input wire logic batteryAbove,
    input wire logic [15:0] stageSourceSelect,
    output logic [NSTAGES-1:0] stageSerialOn
);
    // ==========================================
    // elaboration check
    if (NSTAGES != 18) begin : g_bad_size
        $error("register layout serves exactly 18 stages");
    end

    function automatic logic isOp(input logic valid, input scd_op_t code, input scd_op_t op);
        return valid && (code == op);
    endfunction

    // ==========================================
    // battery status, two-flop sync
    logic battMeta_q;
    logic battSync_q;
    always_ff @(posedge mclk) begin
        battMeta_q <= batteryAbove;
        battSync_q <= battMeta_q;
    end

    // ==========================================
    // fault store
    logic clearReq;
    logic [2*NSTAGES-1:0] faultCode;
    assign clearReq = isOp(cmdValid, cmdCode, `SCD_OP_CLEAR_FAULTS);

    scd_fault_latch #(.NSTAGES(NSTAGES)) u_fault (
        .mclk(mclk),
        .srst(srst),
        .faultLive(stageFault),
        .clearReq(clearReq),
        .faultCode(faultCode)
    );

    // ==========================================
    // command registers
    scd_byte_t cmdLow_q, cmdLow_d;
    scd_byte_t cmdMid_q, cmdMid_d;
    logic [1:0] cmdHigh_q, cmdHigh_d;
    logic [NSTAGES-1:0] serialOn_q, serialOn_d;
    logic [NSTAGES-1:0] cmdAll;

    assign cmdAll = {cmdHigh_q, cmdMid_q, cmdLow_q};

    always_comb begin
        cmdLow_d = cmdLow_q;
        cmdMid_d = cmdMid_q;
        cmdHigh_d = cmdHigh_q;
        // (RULE14) update on accepted frame
        if (isOp(cmdValid, cmdCode, `SCD_OP_WR_CMD_LOW)) begin
            cmdLow_d = cmdData;
        end
        if (isOp(cmdValid, cmdCode, `SCD_OP_WR_CMD_MID)) begin
            cmdMid_d = cmdData;
        end
        // (RULE4) upper six bits dropped
        if (isOp(cmdValid, cmdCode, `SCD_OP_WR_CMD_HIGH)) begin
            cmdHigh_d = cmdData[1:0];
        end
        // (RULE11) zero means on; stages 17, 18 always serial
        serialOn_d = ~cmdAll & {2'b11, ~stageSourceSelect};
    end

    // (RULE1) (RULE2) command registers reset to all ones, serial-on outputs to zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmdLow_q <= `SCD_CMD_RESET;
            cmdMid_q <= `SCD_CMD_RESET;
            cmdHigh_q <= 2'b11;
            serialOn_q <= '0;
        end else begin
            cmdLow_q <= cmdLow_d;
            cmdMid_q <= cmdMid_d;
            cmdHigh_q <= cmdHigh_d;
            serialOn_q <= serialOn_d;
        end
    end

    assign stageSerialOn = serialOn_q;

    // ==========================================
    // read path
    scd_byte_t rdData_q, rdData_d;
    logic rdValid_q, rdValid_d;

    always_comb begin
        rdValid_d = cmdValid;
        rdData_d = `SCD_NO_READ;
        case (cmdCode)
            `SCD_OP_RD_CMD_LOW: rdData_d = cmdLow_q;
            `SCD_OP_RD_CMD_MID: rdData_d = cmdMid_q;
            // (RULE3) unused bits read one
            `SCD_OP_RD_CMD_HIGH: rdData_d = {`SCD_HIGH_UNUSED, cmdHigh_q};
            // (RULE5) stages 1 to 4
            `SCD_OP_RD_FAULT_ONE: rdData_d = faultCode[7:0];
            // (RULE6) stages 5 to 8
            `SCD_OP_RD_FAULT_TWO: rdData_d = faultCode[15:8];
            // (RULE7) stages 9 to 12
            `SCD_OP_RD_FAULT_THREE: rdData_d = faultCode[23:16];
            // (RULE8) stages 13 to 16
            `SCD_OP_RD_FAULT_FOUR: rdData_d = faultCode[31:24];
            // (RULE12) battery live, not latched
            `SCD_OP_RD_FAULT_FIVE: rdData_d = {`SCD_FIVE_UNUSED, battSync_q, faultCode[35:32]};
            // non-read frames leave the last answer standing
            default: begin
                rdValid_d = 1'b0;
                rdData_d = rdData_q;
            end
        endcase
        if (!cmdValid) begin
            rdData_d = rdData_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdData_q <= `SCD_NO_READ;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign rdData = rdData_q;
    assign rdValid = rdValid_q;

    // ==========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence wrLow_s;
        cmdValid && cmdCode == `SCD_OP_WR_CMD_LOW;
    endsequence
    sequence rdLow_s;
        cmdValid && cmdCode == `SCD_OP_RD_CMD_LOW;
    endsequence

    low_write_read_a: assert property (wrLow_s ##1 rdLow_s |=> rdValid && rdData == $past(cmdData, 2))
        else $error("command low readback wrong"); // (RULE1)
    mid_reset_a: assert property ($fell(srst) |-> cmdMid_q == `SCD_CMD_RESET && cmdLow_q == `SCD_CMD_RESET)
        else $error("command reset value wrong"); // (RULE2)
    high_unused_a: assert property (cmdValid && cmdCode == `SCD_OP_RD_CMD_HIGH |=> rdData[7:2] == 6'h3f)
        else $error("unused command bits not one"); // (RULE3)
    high_write_a: assert property (cmdValid && cmdCode == `SCD_OP_WR_CMD_HIGH |=> cmdHigh_q == $past(cmdData[1:0]))
        else $error("stage 17/18 command not stored"); // (RULE4)
    fault_one_a: assert property (cmdValid && cmdCode == `SCD_OP_RD_FAULT_ONE |=> rdData == $past(faultCode[7:0]))
        else $error("fault one packing wrong"); // (RULE5)
    fault_four_a: assert property (cmdValid && cmdCode == `SCD_OP_RD_FAULT_FOUR |=> rdData == $past(faultCode[31:24]))
        else $error("fault four packing wrong"); // (RULE8)
    fault_five_a: assert property (cmdValid && cmdCode == `SCD_OP_RD_FAULT_FIVE
        |=> rdData[7:4] == {3'h7, $past(battSync_q)})
        else $error("fault five upper bits wrong"); // (RULE12)
    serial_on_a: assert property (wrLow_s ##1 !stageSourceSelect[0]
        |=> stageSerialOn[0] == ~$past(cmdData[0], 2))
        else $error("serial stage follows wrong level"); // (RULE11)
endmodule // scd_regs

/* testbench/scd_host_model.sv */
// controller-side frame driver for the register bank
module scd_host_model import scd_pkg::*; (
    input wire logic mclk,
    output logic cmdValid,
    output scd_op_t cmdCode,
    output scd_byte_t cmdData
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // frame issue, entered at a falling edge; valid is held for back-to-back frames
    // any data byte allowed
    task automatic send(input scd_op_t op, input scd_byte_t d);
        cmdValid = 1'b1;
        cmdCode = op;
        cmdData = d;
        @(negedge mclk);
    endtask
    // fields mean nothing when idle, so scramble them rather than hold them
    task automatic idle();
        cmdValid = 1'b0;
        cmdCode = ~cmdCode;
        cmdData = ~cmdData;
    endtask
    initial begin
        cmdValid = 1'b0;
        cmdCode = 5'h00;
        cmdData = 8'h00;
    end
endmodule // scd_host_model

/* testbench/test_scd_regs.sv */
// self-checking bench for the command and fault register bank
module test_scd_regs import scd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, srst, cmdValid, rdValid, batteryAbove;
    scd_op_t cmdCode;
    scd_byte_t cmdData, rdData;
    logic [35:0] stageFault, latch, f;
    logic [15:0] stageSourceSelect;
    logic [17:0] stageSerialOn;
    scd_byte_t cmdReg [3];
    scd_byte_t lastRead;
    int fails = 0;
    int checkCount = 0;

    scd_host_model i_scd_host_model (.mclk(mclk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData));
    scd_regs #(.NSTAGES(18)) i_scd_regs (.mclk(mclk), .srst(srst), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdData(cmdData), .rdValid(rdValid), .rdData(rdData), .stageFault(stageFault),
        .batteryAbove(batteryAbove), .stageSourceSelect(stageSourceSelect), .stageSerialOn(stageSerialOn));

    // ==========================================
    // expectations
    function automatic scd_byte_t expRead(scd_op_t op);
        case (op)
            5'h04: return cmdReg[0];
            5'h05: return cmdReg[1];
            5'h06: return cmdReg[2];
            5'h0c: return {3'h7, batteryAbove, latch[35:32]};
            default: return latch[8*(op-5'h08) +: 8];
        endcase
    endfunction
    function automatic logic [17:0] expOn();
        logic [17:0] on;
        on = ~{cmdReg[2][1:0], cmdReg[1], cmdReg[0]};
        on[15:0] = on[15:0] & ~stageSourceSelect;
        return on;
    endfunction

    // ==========================================
    // checks and transfers
    task automatic chk(string what, logic [35:0] exp, logic [35:0] got);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdAll();
        scd_op_t ops [8] = '{5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c};
        foreach (ops[k]) begin
            i_scd_host_model.send(ops[k], 8'($urandom));
            chk("rdValid", 36'h1, {35'h0, rdValid});
            chk("rdData", {28'h0, expRead(ops[k])}, {28'h0, rdData});
            lastRead = expRead(ops[k]);
        end
        i_scd_host_model.idle();
        @(negedge mclk);
    endtask
    // write, then read back in the very next frame
    task automatic wr(int r, scd_byte_t d);
        cmdReg[r] = (r == 2) ? {6'h3f, d[1:0]} : d;
        i_scd_host_model.send(5'h14 + 5'(r), d);
        chk("rdValid", 36'h0, {35'h0, rdValid});
        chk("rdData", {28'h0, lastRead}, {28'h0, rdData});
        i_scd_host_model.send(5'h04 + 5'(r), 8'($urandom));
        i_scd_host_model.idle();
        lastRead = cmdReg[r];
        chk("rdValid", 36'h1, {35'h0, rdValid});
        chk("rdData", {28'h0, lastRead}, {28'h0, rdData});
        chk("stageSerialOn", {18'h0, expOn()}, {18'h0, stageSerialOn});
        @(negedge mclk);
    endtask
    // live code held long enough to pass the synchronisers; newest fault wins
    task automatic applyLive(logic [35:0] v);
        stageFault = v;
        batteryAbove = 1'($urandom);
        repeat (4) @(negedge mclk);
        for (int s = 0; s < 18; s++) begin
            if (v[2*s +: 2] != 2'h3) latch[2*s +: 2] = v[2*s +: 2];
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================
    // clock, watchdog and sequence
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #(25 * 5000);
        fails++;
        conclude();
    end
    initial begin
        srst = 1'b1;
        stageFault = '1;
        batteryAbove = 1'b1;
        stageSourceSelect = 16'h0000;
        cmdReg = '{8'hff, 8'hff, 8'hff};
        latch = '1;
        lastRead = 8'hff;
        void'($urandom(58));
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        chk("rdData", 36'hff, {28'h0, rdData});
        chk("stageSerialOn", 36'h0, {18'h0, stageSerialOn});
        rdAll();
        $display("test reset values done");
        for (int i = 0; i < 30; i++) begin
            stageSourceSelect = 16'($urandom);
            wr(i % 3, (i < 3) ? 8'h00 : 8'($urandom));
            rdAll();
        end
        $display("test command registers done");
        for (int i = 0; i < 20; i++) begin
            f = 36'({$urandom, $urandom});
            if (i[0]) f[17:0] = '1;
            applyLive(f);
            // unmapped code: no answer, fault state untouched
            i_scd_host_model.send(5'h17, 8'h00);
            i_scd_host_model.idle();
            chk("rdValid", 36'h0, {35'h0, rdValid});
            chk("rdData", {28'h0, lastRead}, {28'h0, rdData});
            @(negedge mclk);
            rdAll();
            f = f | 36'({$urandom, $urandom});
            applyLive(f);
            i_scd_host_model.send(5'h18, 8'($urandom));
            i_scd_host_model.idle();
            latch = f;
            @(negedge mclk);
            rdAll();
        end
        $display("test fault registers done");
        conclude();
    end
endmodule // test_scd_regs
